// File: rtl/adc_ctl_pkg.sv
// shared constants for the converter serial readout and power-down control
package adc_ctl_pkg;
  // result word
  localparam int          WORD_W      = 24;
  localparam logic [23:0] POS_FULL    = 24'h7FFFFF;
  localparam logic [23:0] NEG_FULL    = 24'h800000;
  // conversion cycle partition, in system clocks
  localparam int          CYCLE_CLKS  = 384;
  localparam int          WRITE_CLKS  = 6;
  localparam int          LOW_CLKS    = 6;
  localparam int          HIGH_CLKS   = 6;
  localparam int          READY_CLKS  = 36;
  localparam int          TAIL_CLKS   = 24;
  localparam int          PHASE_W     = 9;
  localparam int          LOW_START   = WRITE_CLKS;
  localparam int          HIGH_START  = WRITE_CLKS + LOW_CLKS;
  localparam int          DATA_START  = READY_CLKS;
  localparam int          TAIL_START  = CYCLE_CLKS - TAIL_CLKS;
  // synchronisation and power-down
  localparam int          SYNC_PERIODS = 4;
  localparam int          PD_PERIODS   = 20;
  localparam int          SYNC_PULSE_CLKS = 3;
  localparam int          PD_WAIT_CLKS =
    (PD_PERIODS - SYNC_PERIODS) * CYCLE_CLKS;
  localparam int          SYNC_FIRST_CLKS = 2042;
  localparam int          WAKE_CLKS   = 592;
  localparam int          TIMER_W     = 13;
  localparam int          HOLD_W      = 3;
  // result trust
  localparam int          VALID_PULSE = 6;
  localparam int          PULSE_W     = 3;
  // sample queue
  localparam int          FIFO_DEPTH  = 16;
endpackage : adc_ctl_pkg

// File: rtl/adc_serial_readout.sv
// converter serial readout, synchronisation and power-down control
//
// Summary of operation
// - serial clock high for 20 periods places the converter in power-down
// - after four high periods: line low three clocks, then high, mod reset
// - 16 more high periods enter power-down; serial clock fall leaves it
// - first ready pulse after wake comes 600 clocks after the fall
// - results before the sixth ready pulse after release are invalid
// - each result leaves as 24-bit two's complement, MSB first
// - results saturate at 7FFFFF and 800000, zero is 000000
// - ready phase: 6 clocks write, 6 clocks low, 24 clocks high
// - cycle is 384 clocks: 36 ready, 348 data ending in 24 high
// - synchronisation starts between 1537 and 7679 clocks after rise
// - power-down never before 7681 clocks after the rise
// - power-down starts 6144 clocks after the sync pulse ends
// - host may read from the first pulse; valid from the sixth
// - bits change on serial clock falls; host samples on rises
// - four to 19 high periods only synchronise; release on fall
// - idle shows MSB, partial read last bit, overrun reads low
// - bit pointer resets at register write and at tail interval
`timescale 1ns/1ps
module adc_serial_readout #(
  parameter int IN_W    = 26,
  parameter int DEPTH   = adc_ctl_pkg::FIFO_DEPTH,
  parameter int PD_WAIT = adc_ctl_pkg::PD_WAIT_CLKS
) (
  input  wire logic            ref_clk,
  input  wire logic            reset,
  input  wire logic            ce,
  input  wire logic            sclk,
  input  wire logic [IN_W-1:0] sample_data,
  input  wire logic            sample_valid,
  output logic                 sample_ready,
  output logic                 data_ready_line,
  output logic                 modulator_reset,
  output logic                 power_down,
  output logic                 result_valid
);
  typedef enum logic [2:0] {
    ST_RUN, ST_SYNC_PULSE, ST_SYNC_HOLD, ST_POWER_DOWN, ST_WAIT
  } state_t;

  localparam int W = adc_ctl_pkg::WORD_W;
  localparam logic [adc_ctl_pkg::TIMER_W-1:0] PD_LAST =
    adc_ctl_pkg::TIMER_W'(PD_WAIT - 1);

  // clamp a wide signed sample into the 24-bit output range
  function automatic logic [23:0] saturate(input logic [IN_W-1:0] s);
    logic signed [IN_W-1:0] v;
    v = signed'(s);
    if (v > signed'(IN_W'(adc_ctl_pkg::POS_FULL))) begin
      saturate = adc_ctl_pkg::POS_FULL;
    end else if (v < -signed'(IN_W'(adc_ctl_pkg::POS_FULL)) - 1) begin
      saturate = adc_ctl_pkg::NEG_FULL;
    end else begin
      saturate = s[23:0];
    end
  endfunction : saturate

  logic                sc_level, sc_rise, sc_fall;
  logic [W-1:0]        sat_word;
  result_stream_if #(.W(W)) rs ();

  serial_clock_sampler u_sampler (
    .ref_clk (ref_clk),
    .reset   (reset),
    .ce      (ce),
    .sclk    (sclk),
    .level   (sc_level),
    .rise    (sc_rise),
    .fall    (sc_fall)
  );

  assign sat_word = saturate(sample_data);

  result_fifo #(.W(W), .D(DEPTH)) u_fifo (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .ce       (ce),
    .in_data  (sat_word),
    .in_valid (sample_valid),
    .in_ready (sample_ready),
    .out      (rs)
  );

  state_t                           st_q, st_d;
  logic [adc_ctl_pkg::PHASE_W-1:0]  phase_q, phase_d;
  logic [adc_ctl_pkg::TIMER_W-1:0]  timer_q, timer_d;
  logic [adc_ctl_pkg::HOLD_W-1:0]   hold_q, hold_d;
  logic [adc_ctl_pkg::PULSE_W-1:0]  pulses_q, pulses_d;
  logic [4:0]                       ptr_q, ptr_d;
  logic [W-1:0]                     word_q, word_d;
  logic                             high_all_q, high_all_d;
  logic                             line_q, line_d;
  logic                             valid_q, valid_d;
  logic                             period_end;

  // readout sequencer: cycle partition, shift, sync and power-down
  always_comb begin
    st_d       = st_q;
    phase_d    = phase_q;
    timer_d    = timer_q;
    hold_d     = hold_q;
    pulses_d   = pulses_q;
    ptr_d      = ptr_q;
    word_d     = word_q;
    high_all_d = high_all_q;
    line_d     = 1'b1;
    rs.ready   = 1'b0;
    period_end = (phase_q == adc_ctl_pkg::PHASE_W'(
                  adc_ctl_pkg::CYCLE_CLKS - 1));
    case (st_q)
      ST_RUN: begin
        phase_d = period_end ? '0 : phase_q + 1'b1;
        // pointer restart and register load at the write interval
        if (phase_q == '0) begin
          ptr_d    = '0;
          rs.ready = 1'b1;
          if (rs.valid) begin
            word_d = rs.data;
          end
        end
        if (phase_q == adc_ctl_pkg::PHASE_W'(adc_ctl_pkg::TAIL_START)) begin
          ptr_d = '0;
        end
        if (phase_q == adc_ctl_pkg::PHASE_W'(adc_ctl_pkg::LOW_START) &&
            pulses_q != adc_ctl_pkg::PULSE_W'(adc_ctl_pkg::VALID_PULSE)) begin
          pulses_d = pulses_q + 1'b1;
        end
        // bits advance on host clock falls during the data phase
        if (phase_q >= adc_ctl_pkg::PHASE_W'(adc_ctl_pkg::DATA_START) &&
            phase_q < adc_ctl_pkg::PHASE_W'(adc_ctl_pkg::TAIL_START) &&
            sc_fall && ptr_q != 5'(W)) begin
          ptr_d = ptr_q + 1'b1;
        end
        // line level across the partition
        if (phase_q < adc_ctl_pkg::PHASE_W'(adc_ctl_pkg::LOW_START)) begin
          line_d = 1'b1;
        end else if (phase_q <
                     adc_ctl_pkg::PHASE_W'(adc_ctl_pkg::HIGH_START)) begin
          line_d = 1'b0;
        end else if (phase_q <
                     adc_ctl_pkg::PHASE_W'(adc_ctl_pkg::DATA_START)) begin
          line_d = 1'b1;
        end else if (phase_q <
                     adc_ctl_pkg::PHASE_W'(adc_ctl_pkg::TAIL_START)) begin
          // overrun reads low; otherwise the current bit, MSB first
          line_d = (ptr_q == 5'(W)) ? 1'b0 :
                   word_q[5'(W - 1) - ptr_q];
        end else begin
          line_d = 1'b1;
        end
        // high-hold period counting; any low sample clears it
        if (!sc_level) begin
          high_all_d = 1'b0;
          hold_d     = '0;
        end
        if (period_end) begin
          high_all_d = 1'b1;
          if (high_all_q && sc_level) begin
            hold_d = hold_q + 1'b1;
            if (hold_q == adc_ctl_pkg::HOLD_W'(
                adc_ctl_pkg::SYNC_PERIODS - 1)) begin
              st_d    = ST_SYNC_PULSE;
              timer_d = '0;
            end
          end else begin
            hold_d = '0;
          end
        end
      end
      ST_SYNC_PULSE: begin
        line_d  = 1'b0;
        timer_d = timer_q + 1'b1;
        if (timer_q == adc_ctl_pkg::TIMER_W'(
            adc_ctl_pkg::SYNC_PULSE_CLKS - 1)) begin
          st_d    = ST_SYNC_HOLD;
          timer_d = '0;
        end
      end
      ST_SYNC_HOLD: begin
        timer_d = timer_q + 1'b1;
        if (sc_fall) begin
          st_d     = ST_WAIT;
          timer_d  = adc_ctl_pkg::TIMER_W'(adc_ctl_pkg::SYNC_FIRST_CLKS);
          pulses_d = '0;
        end else if (timer_q == PD_LAST) begin
          st_d = ST_POWER_DOWN;
        end
      end
      ST_POWER_DOWN: begin
        if (sc_fall) begin
          st_d     = ST_WAIT;
          timer_d  = adc_ctl_pkg::TIMER_W'(adc_ctl_pkg::WAKE_CLKS);
          pulses_d = '0;
        end
      end
      ST_WAIT: begin
        // the first write interval starts when the timer runs out
        timer_d = timer_q - 1'b1;
        if (timer_q == adc_ctl_pkg::TIMER_W'(1)) begin
          st_d       = ST_RUN;
          phase_d    = '0;
          hold_d     = '0;
          high_all_d = 1'b1;
        end
      end
      default: begin
        st_d = ST_RUN;
      end
    endcase
    valid_d = (pulses_d == adc_ctl_pkg::PULSE_W'(
               adc_ctl_pkg::VALID_PULSE));
  end

  // sequencer registers; the line idles high from reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q       <= ST_RUN;
      phase_q    <= '0;
      timer_q    <= '0;
      hold_q     <= '0;
      pulses_q   <= '0;
      ptr_q      <= '0;
      word_q     <= '0;
      high_all_q <= 1'b0;
      line_q     <= 1'b1;
      valid_q    <= 1'b0;
    end else if (ce) begin
      st_q       <= st_d;
      phase_q    <= phase_d;
      timer_q    <= timer_d;
      hold_q     <= hold_d;
      pulses_q   <= pulses_d;
      ptr_q      <= ptr_d;
      word_q     <= word_d;
      high_all_q <= high_all_d;
      line_q     <= line_d;
      valid_q    <= valid_d;
    end
  end

  // outputs; the modulator stays in reset until the host clock falls
  assign data_ready_line = line_q;
  assign modulator_reset = (st_q == ST_SYNC_PULSE) ||
                           (st_q == ST_SYNC_HOLD) ||
                           (st_q == ST_POWER_DOWN);
  assign power_down      = (st_q == ST_POWER_DOWN);
  assign result_valid    = valid_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset || !ce);

  a_low_pulse_len: assert property (
    (st_q == ST_RUN && phase_q == 9'(adc_ctl_pkg::LOW_START))
    |=> !data_ready_line [*6] ##1 data_ready_line)
    else $error("ready low time wrong");
  a_cycle_wrap: assert property (
    (st_q == ST_RUN && phase_q == 9'(adc_ctl_pkg::CYCLE_CLKS - 1) &&
     st_d == ST_RUN) |=> phase_q == '0)
    else $error("cycle length wrong");
  // the pin lags the state by one clock, so it is still high on entry
  a_sync_pulse_len: assert property (
    $rose(st_q == ST_SYNC_PULSE)
    |-> data_ready_line ##1 !data_ready_line [*3] ##1
        (data_ready_line && st_q == ST_SYNC_HOLD))
    else $error("sync pulse length wrong");
  a_pd_from_hold: assert property (
    $rose(power_down) |-> $past(st_q) == ST_SYNC_HOLD &&
                          $past(timer_q) == PD_LAST)
    else $error("power-down entered early");
  // one clock loads the wake timer, then it runs its full count
  a_wake_delay: assert property (
    (st_q == ST_POWER_DOWN && sc_fall)
    |-> ##[593:593] (st_q == ST_RUN && phase_q == '0))
    else $error("wake delay wrong");
  a_msb_first: assert property (
    (st_q == ST_RUN && phase_q == 9'(adc_ctl_pkg::DATA_START) &&
     ptr_q == '0) |=> data_ready_line == word_q[23])
    else $error("first data bit not MSB");
  a_overrun_low: assert property (
    (st_q == ST_RUN && ptr_q == 5'(W) &&
     phase_q > 9'(adc_ctl_pkg::DATA_START) &&
     phase_q < 9'(adc_ctl_pkg::TAIL_START)) |=> !data_ready_line)
    else $error("overrun does not read low");
  a_hold_clear: assert property (
    (st_q == ST_RUN && !sc_level) |=> hold_q == '0)
    else $error("hold count not cleared");
  a_valid_sixth: assert property (
    $rose(result_valid) |-> $past(pulses_q) == 3'd5)
    else $error("valid before sixth pulse");
  a_sat_range: assert property (
    (signed'(sample_data) > signed'(IN_W'(adc_ctl_pkg::POS_FULL)))
    |-> sat_word == adc_ctl_pkg::POS_FULL)
    else $error("positive saturation wrong");
  a_ptr_restart: assert property (
    (st_q == ST_RUN && phase_q == 9'(adc_ctl_pkg::TAIL_START))
    |=> ptr_q == '0)
    else $error("bit pointer not restarted");
  a_release_fall: assert property (
    (st_q == ST_SYNC_HOLD && sc_fall) |=> (st_q == ST_WAIT && !modulator_reset))
    else $error("sync hold not released on fall");
endmodule : adc_serial_readout

// File: rtl/result_fifo.sv
// result queue with registered read data and valid/ready on both sides
`timescale 1ns/1ps
module result_fifo #(
  parameter int W = 24,
  parameter int D = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  result_stream_if.src      out
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic [W-1:0]  rdata_q, rdata_d;
  logic          push, pop;

  // pointer and count update; read data follows the next read pointer
  always_comb begin
    // the count is one bit wider than the pointers, so size the depth to it
    in_ready  = (cnt_q != (AW+1)'(D));
    out.valid = (cnt_q != '0);
    out.data  = rdata_q;
    push      = in_valid && in_ready;
    pop       = out.valid && out.ready;
    wr_d      = push ? wr_q + 1'b1 : wr_q;
    rd_d      = pop ? rd_q + 1'b1 : rd_q;
    cnt_d     = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    // bypass avoids reading a word that is written in this very cycle
    rdata_d   = (push && wr_q == rd_d) ? in_data : mem[rd_d];
  end

  // state registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_q    <= '0;
      rd_q    <= '0;
      cnt_q   <= '0;
      rdata_q <= '0;
    end else if (ce) begin
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      cnt_q   <= cnt_d;
      rdata_q <= rdata_d;
    end
  end

  // storage array, no reset needed
  always_ff @(posedge ref_clk) begin
    if (ce && push) begin
      mem[wr_q] <= in_data;
    end
  end
endmodule : result_fifo

// File: rtl/result_stream_if.sv
// stream of saturated results from the queue to the readout logic
`timescale 1ns/1ps
interface result_stream_if #(
  parameter int W = 24
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : result_stream_if

// File: rtl/serial_clock_sampler.sv
// two-stage synchroniser and edge finder for the host serial clock
`timescale 1ns/1ps
module serial_clock_sampler (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic ce,
  input  wire logic sclk,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_q, sync_q, prev_q;
  logic meta_d, sync_d, prev_d;

  // only sync_q and prev_q feed logic; meta_q goes to sync_q alone
  always_comb begin
    meta_d = sclk;
    sync_d = meta_q;
    prev_d = sync_q;
    level  = sync_q;
    rise   = sync_q && !prev_q;
    fall   = !sync_q && prev_q;
  end

  // synchroniser registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (ce) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end
endmodule : serial_clock_sampler

// File: test/host_model.sv
// host side model: drives the serial clock and samples the data pin
`timescale 1ns/1ps
module host_model (
  output logic      sclk,
  input  wire logic data_ready_line
);
  // the clock rests low outside frames, as a real host leaves it
  initial sclk = 1'b0;

  // hold or drop the clock level for synchronisation and power-down
  task automatic set_level(input logic v);
    sclk = v;
  endtask : set_level

  // one bit per 160 ns; the odd start offset keeps phase unrelated
  task automatic read_bits(input int n, output logic [23:0] word);
    word = 24'h000000;
    #3;
    for (int i = 0; i < n; i++) begin
      #80 sclk = 1'b1;
      word = {word[22:0], data_ready_line};
      #80 sclk = 1'b0;
    end
  endtask : read_bits
endmodule : host_model

// File: test/tb.sv
// self-checking bench for the converter readout control
`timescale 1ns/1ps
module tb;
  localparam int PDW   = adc_ctl_pkg::PD_WAIT_CLKS;
  localparam int LIMIT = 40000;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        ce = 1'b1;
  logic [25:0] sample_data = 26'h0000000;
  logic        sample_valid = 1'b0;
  logic        sclk;
  logic        sample_ready;
  logic        data_ready_line;
  logic        modulator_reset;
  logic        power_down;
  logic        result_valid;
  int          errors = 0;
  int          checks = 0;
  int          cycles = 0;
  int          last_fall = 0;
  // raw filter words and the saturated results they must give
  logic [25:0] raw [8] = '{26'h0000000, 26'h3FFFFFF, 26'h0FFFFFF,
    26'h2000000, 26'h07FFFFF, 26'h37FFFFF, 26'h0123456, 26'h3EDCBA9};
  logic [23:0] sat [8] = '{24'h000000, 24'hFFFFFF, 24'h7FFFFF,
    24'h800000, 24'h7FFFFF, 24'h800000, 24'h123456, 24'hEDCBA9};

  always #10 ref_clk = ~ref_clk;

  adc_serial_readout #(.PD_WAIT(PDW)) adc_serial_readout_inst (
    .ref_clk         (ref_clk),
    .reset           (reset),
    .ce              (ce),
    .sclk            (sclk),
    .sample_data     (sample_data),
    .sample_valid    (sample_valid),
    .sample_ready    (sample_ready),
    .data_ready_line (data_ready_line),
    .modulator_reset (modulator_reset),
    .power_down      (power_down),
    .result_valid    (result_valid)
  );
  host_model host_model_inst (
    .sclk            (sclk),
    .data_ready_line (data_ready_line)
  );

  task automatic summarize;
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // cycle budget cuts a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles >= LIMIT) begin
      errors++;
      summarize();
    end
  end

  task automatic cmp_bit(input string s, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %b seen %b", s, e, g);
    end
  endtask : cmp_bit

  task automatic cmp_word(input string s, input logic [23:0] e,
                          input logic [23:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask : cmp_word

  task automatic cmp_range(input string s, input int lo, input int hi,
                           input int g);
    checks++;
    if (g < lo || g > hi) begin
      errors++;
      $display("BAD %s expected %0d..%0d seen %0d", s, lo, hi, g);
    end
  endtask : cmp_range

  // clocks until the pin reads low, sampled on falling edges
  task automatic wait_low(output int n);
    n = 0;
    while (data_ready_line !== 1'b0 && n < 9000) begin
      @(negedge ref_clk);
      n++;
    end
  endtask : wait_low

  // next high-to-low ready edge: gap since the last one, high run, width
  task automatic next_ready(output int gap, output int hi, output int lo);
    int n;
    hi = 0;
    lo = 0;
    n = 0;
    @(negedge ref_clk);
    while (!(hi > 0 && data_ready_line === 1'b0) && n < 3000) begin
      hi = (data_ready_line === 1'b1) ? hi + 1 : 0;
      n++;
      @(negedge ref_clk);
    end
    gap = cycles - last_fall;
    last_fall = cycles;
    while (data_ready_line === 1'b0 && lo < 50) begin
      lo++;
      @(negedge ref_clk);
    end
  endtask : next_ready

  // clocks until modulator reset, then width of the short low pulse
  task automatic sync_pulse(output int n, output int lo);
    int m;
    n = 0;
    lo = 0;
    while (modulator_reset !== 1'b1 && n < 9000) begin
      @(negedge ref_clk);
      n++;
    end
    wait_low(m);
    while (data_ready_line === 1'b0 && lo < 50) begin
      @(negedge ref_clk);
      lo++;
    end
  endtask : sync_pulse

  // fill the queue until refused, then read the words in three ways in turn
  task automatic test_stream;
    int k, gap, hi, lo, mode;
    logic [23:0] w, e;
    logic prev_low;
    cmp_bit("pin at reset", 1'b1, data_ready_line);
    cmp_bit("valid at reset", 1'b0, result_valid);
    wait_low(k);
    k = 0;
    @(posedge ref_clk);
    #1 sample_valid = 1'b1;
    sample_data = raw[0];
    @(negedge ref_clk);
    while (sample_ready === 1'b1 && k < 20) begin
      @(posedge ref_clk);
      k++;
      #1 sample_data = raw[k % 8];
      @(negedge ref_clk);
    end
    cmp_range("words taken", 16, 16, k);
    repeat (3) @(posedge ref_clk);
    #1 sample_valid = 1'b0;
    repeat (40) @(negedge ref_clk);
    prev_low = 1'b0;
    for (k = 0; k < 16; k++) begin
      next_ready(gap, hi, lo);
      if (k > 0) cmp_range("cycle length", 384, 384, gap);
      cmp_range("ready low", 6, 6, lo);
      if (prev_low) cmp_range("high run", 30, 30, hi);
      repeat (5) @(negedge ref_clk);
      cmp_bit("high before data", 1'b1, data_ready_line);
      repeat (21) @(negedge ref_clk);
      e = sat[k % 8];
      cmp_bit("idle msb", e[23], data_ready_line);
      mode = k % 3;
      if (mode == 0) begin
        repeat (200) @(negedge ref_clk);
        cmp_bit("untouched msb", e[23], data_ready_line);
      end else if (mode == 1) begin
        host_model_inst.read_bits(10, w);
        cmp_word("partial", {14'h0000, e[23:14]}, w);
        repeat (40) @(negedge ref_clk);
        cmp_bit("last bit", e[13], data_ready_line);
      end else begin
        host_model_inst.read_bits(24, w);
        cmp_word("word", e, w);
        repeat (4) @(negedge ref_clk);
        cmp_bit("overrun", 1'b0, data_ready_line);
      end
      prev_low = (mode == 2);
    end
    cmp_bit("queue drained", 1'b1, sample_ready);
    cmp_bit("valid after six", 1'b1, result_valid);
  endtask : test_stream

  // a dropped hold restarts the count; a short hold only synchronises
  task automatic test_sync;
    int n, lo;
    @(posedge ref_clk);
    #1 host_model_inst.set_level(1'b1);
    repeat (1200) @(posedge ref_clk);
    #1 host_model_inst.set_level(1'b0);
    repeat (3) @(posedge ref_clk);
    #1 host_model_inst.set_level(1'b1);
    sync_pulse(n, lo);
    cmp_range("rise to sync", 1537, 7679, n);
    cmp_range("sync pulse", 3, 3, lo);
    n = 0;
    repeat (1000) begin
      @(negedge ref_clk);
      if (data_ready_line !== 1'b1 || power_down !== 1'b0) n++;
    end
    cmp_range("held high", 0, 0, n);
    cmp_bit("modulator held", 1'b1, modulator_reset);
    @(posedge ref_clk);
    #1 host_model_inst.set_level(1'b0);
    n = 0;
    while (modulator_reset !== 1'b0 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    cmp_range("release on fall", 1, 5, n);
    cmp_bit("valid cleared", 1'b0, result_valid);
  endtask : test_sync

  // long hold into power-down, wake on the fall, count pulses to valid
  task automatic test_powerdown;
    int n, gap, hi, lo, s;
    next_ready(gap, hi, lo);
    @(posedge ref_clk);
    #1 host_model_inst.set_level(1'b1);
    sync_pulse(n, lo);
    cmp_range("rise to sync", 1537, 7679, n);
    s = n + lo + 1;
    n = 0;
    while (power_down !== 1'b1 && n < 9000) begin
      @(negedge ref_clk);
      n++;
    end
    cmp_range("sync to power-down", PDW - 2, PDW + 2, n);
    cmp_range("rise to power-down", 7681, 7679 + PDW, s + n);
    cmp_bit("modulator off", 1'b1, modulator_reset);
    repeat (100) @(negedge ref_clk);
    cmp_bit("power-down holds", 1'b1, power_down);
    @(posedge ref_clk);
    #1 host_model_inst.set_level(1'b0);
    wait_low(n);
    cmp_range("wake to ready", 599, 604, n);
    cmp_bit("awake", 1'b0, power_down);
    for (int p = 1; p <= 6; p++) begin
      if (p > 1) next_ready(gap, hi, lo);
      else while (data_ready_line === 1'b0) @(negedge ref_clk);
      if (p > 2) cmp_range("cycle after wake", 384, 384, gap);
      cmp_bit("valid by pulse", p == 6, result_valid);
    end
  endtask : test_powerdown

  // clock enable low stalls the cycle; it resumes where it stopped
  task automatic test_freeze;
    int n, gap, hi, lo;
    logic held;
    @(posedge ref_clk);
    #1 ce = 1'b0;
    held = data_ready_line;
    n = 0;
    repeat (100) begin
      @(negedge ref_clk);
      if (data_ready_line !== held || result_valid !== 1'b1) n++;
    end
    @(posedge ref_clk);
    #1 ce = 1'b1;
    cmp_range("frozen pin", 0, 0, n);
    next_ready(gap, hi, lo);
    cmp_range("stalled cycle", 484, 484, gap);
    cmp_range("ready low after stall", 6, 6, lo);
  endtask : test_freeze

  initial begin
    repeat (16) @(posedge ref_clk);
    #1 reset = 1'b0;
    test_stream();
    test_sync();
    test_powerdown();
    test_freeze();
    summarize();
  end
endmodule : tb
